// ### core/rpfs_sequencer.sv
module rpfs_sequencer #(
  parameter int unsigned RESET_HOLD = rpfs_pkg::RESET_HOLD_CYCLES,
  parameter int unsigned FAULT_HOLD = rpfs_pkg::FAULT_HOLD_CYCLES,
  parameter int unsigned WDOG_HOLD  = rpfs_pkg::WDOG_HOLD_CYCLES
) (
  input  wire logic          sys_clk_in,
  input  wire logic          rst_in,
  input  wire logic          ext_reset_in,
  input  wire logic          power_fault_sense_input_in,
  input  wire logic          hardware_watchdog_overflow_in,
  output rpfs_pkg::rpfs_ctrl_t ctrl_out,
  output logic               rtc_run_out
);

  // ************************************************************
  // parameter checks
  // ************************************************************
  localparam int unsigned CW = 13;

  // refused at elaboration: the counter cannot serve these holds
  if (RESET_HOLD < 2 || RESET_HOLD >= (1 << CW))
  begin
    $error("reset hold count out of range");
  end
  if (FAULT_HOLD < 2 || FAULT_HOLD >= (1 << CW))
  begin
    $error("fault hold count out of range");
  end
  if (WDOG_HOLD < 2 || WDOG_HOLD >= (1 << CW))
  begin
    $error("watchdog hold count out of range");
  end

  localparam logic [CW-1:0] RESET_LAST = CW'(RESET_HOLD - 1);
  localparam logic [CW-1:0] FAULT_LAST = CW'(FAULT_HOLD - 1);
  localparam logic [CW-1:0] WDOG_LAST  = CW'(WDOG_HOLD - 1);

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic ext_reset_s;
  logic pwr_good_s;
  logic wdog_ov;

  rpfs_sync #(.RESET_VALUE(1'b0)) u_sync_reset (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .async_in   (ext_reset_in),
    .sync_out   (ext_reset_s)
  );

  // power assumed good at start so no spurious fault
  rpfs_sync #(.RESET_VALUE(1'b1)) u_sync_fault (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .async_in   (power_fault_sense_input_in),
    .sync_out   (pwr_good_s)
  );

  // watchdog runs on this clock already, so no synchroniser
  assign wdog_ov = hardware_watchdog_overflow_in;

  // ************************************************************
  // state machine and hold counter
  // ************************************************************
  rpfs_pkg::rpfs_state_t state_q;
  rpfs_pkg::rpfs_state_t state_d;
  logic [CW-1:0]         cnt_q;
  logic [CW-1:0]         cnt_d;
  logic [CW-1:0]         last_q;
  logic [CW-1:0]         last_d;
  logic                  keep_cfg_q;
  logic                  keep_cfg_d;
  logic                  from_fault_q;
  logic                  from_fault_d;

  // fault wins over external reset, external reset wins over watchdog
  always_comb
  begin
    state_d      = state_q;
    cnt_d        = cnt_q;
    last_d       = last_q;
    keep_cfg_d   = keep_cfg_q;
    from_fault_d = from_fault_q;
    if (!pwr_good_s)
    begin
      state_d      = rpfs_pkg::RPFS_POWERDOWN;
      from_fault_d = 1'b1;
      cnt_d        = '0;
    end
    else if (ext_reset_s)
    begin
      state_d    = rpfs_pkg::RPFS_EXT_RESET;
      keep_cfg_d = 1'b0;
      cnt_d      = '0;
      last_d     = RESET_LAST;
    end
    else
    begin
      case (state_q)
        rpfs_pkg::RPFS_RUN:
        begin
          if (wdog_ov)
          begin
            state_d    = rpfs_pkg::RPFS_WDOG;
            keep_cfg_d = 1'b1;
            cnt_d      = '0;
            last_d     = WDOG_LAST;
          end
        end
        rpfs_pkg::RPFS_EXT_RESET:
        begin
          // reset input low: start hold count
          state_d = rpfs_pkg::RPFS_HOLD;
          cnt_d   = '0;
        end
        rpfs_pkg::RPFS_WDOG:
        begin
          state_d = rpfs_pkg::RPFS_HOLD;
          cnt_d   = '0;
        end
        rpfs_pkg::RPFS_POWERDOWN:
        begin
          // power back; alignment to crystal gives the spread
          state_d    = rpfs_pkg::RPFS_HOLD;
          keep_cfg_d = 1'b1;
          cnt_d      = '0;
          last_d     = FAULT_LAST;
        end
        rpfs_pkg::RPFS_HOLD:
        begin
          if (cnt_q == last_q)
          begin
            state_d      = rpfs_pkg::RPFS_RUN;
            from_fault_d = 1'b0;
          end
          else
            cnt_d = CW'(cnt_q + 1'b1);
        end
        default:
          state_d = rpfs_pkg::RPFS_EXT_RESET;
      endcase
    end
  end

  // system reset behaves as external reset with defaults loaded
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      state_q      <= rpfs_pkg::RPFS_EXT_RESET;
      cnt_q        <= '0;
      last_q       <= RESET_LAST;
      keep_cfg_q   <= 1'b0;
      from_fault_q <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      cnt_q        <= cnt_d;
      last_q       <= last_d;
      keep_cfg_q   <= keep_cfg_d;
      from_fault_q <= from_fault_d;
    end
  end

  // ************************************************************
  // registered control outputs
  // ************************************************************
  rpfs_pkg::rpfs_ctrl_t ctrl_q;
  rpfs_pkg::rpfs_ctrl_t ctrl_d;

  always_comb
  begin
    ctrl_d                  = '0;
    ctrl_d.start_addr       = rpfs_pkg::BOOT_ADDR;
    ctrl_d.core_reset       = (state_d != rpfs_pkg::RPFS_RUN);
    ctrl_d.digital_halt     = (state_d == rpfs_pkg::RPFS_EXT_RESET) ||
                              (state_d == rpfs_pkg::RPFS_WDOG);
    ctrl_d.cfg_default_load = (state_d == rpfs_pkg::RPFS_EXT_RESET) &&
                              !keep_cfg_d;
    ctrl_d.synth_stat_clear = (state_d == rpfs_pkg::RPFS_POWERDOWN);
    ctrl_d.power_down       = (state_d == rpfs_pkg::RPFS_POWERDOWN);
    ctrl_d.ram_init         = (state_d == rpfs_pkg::RPFS_HOLD) && from_fault_d;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      ctrl_q                  <= '0;
      ctrl_q.core_reset       <= 1'b1;
      ctrl_q.digital_halt     <= 1'b1;
      ctrl_q.cfg_default_load <= 1'b1;
      ctrl_q.start_addr       <= rpfs_pkg::BOOT_ADDR;
    end
    else
      ctrl_q <= ctrl_d;
  end

  assign ctrl_out    = ctrl_q;
  // oscillator and real-time clock never stopped by reset
  assign rtc_run_out = 1'b1;

  // ************************************************************
  // assertions
  // ************************************************************
  a_ext_halt_core: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ext_reset_s && pwr_good_s) |=> (ctrl_q.core_reset && ctrl_q.digital_halt))
    else $error("core not halted during external reset");

  a_cfg_default_load: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ext_reset_s && pwr_good_s) |=> ctrl_q.cfg_default_load)
    else $error("configuration defaults not loaded");

  a_reset_hold_len: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_q == rpfs_pkg::RPFS_EXT_RESET && !ext_reset_s && pwr_good_s) |=>
      (state_q == rpfs_pkg::RPFS_HOLD && last_q == RESET_LAST && cnt_q == '0))
    else $error("reset hold count not started correctly");

  a_release_on_expiry: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_q == rpfs_pkg::RPFS_HOLD && cnt_q == last_q && pwr_good_s && !ext_reset_s)
      |=> !ctrl_q.core_reset)
    else $error("core not released on timer expiry");

  a_fault_clear_stat: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $fell(pwr_good_s) |=> (ctrl_q.synth_stat_clear && ctrl_q.power_down))
    else $error("fault did not clear status and power down");

  a_fault_hold_min: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_q == rpfs_pkg::RPFS_POWERDOWN && pwr_good_s && !ext_reset_s) |=>
      (last_q == FAULT_LAST && cnt_q == '0 && state_q == rpfs_pkg::RPFS_HOLD))
    else $error("fault recovery hold not armed");

  a_fault_ram_init: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_q == rpfs_pkg::RPFS_HOLD && from_fault_q && pwr_good_s && !ext_reset_s &&
     cnt_q != last_q) |=> ctrl_q.ram_init)
    else $error("processor RAM not reinitialised after fault");

  a_wdog_keep_cfg: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_q == rpfs_pkg::RPFS_RUN && wdog_ov && pwr_good_s && !ext_reset_s) |=>
      (ctrl_q.core_reset && !ctrl_q.cfg_default_load && last_q == WDOG_LAST))
    else $error("watchdog reset handled wrongly");

  a_boot_address: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $fell(ctrl_q.core_reset) |->
      (state_q == rpfs_pkg::RPFS_RUN && ctrl_q.start_addr == rpfs_pkg::BOOT_ADDR))
    else $error("core released with wrong start address");

endmodule

// ### core/rpfs_pkg.sv
package rpfs_pkg;

  // ************************************************************
  // counts of slow crystal clock cycles
  // ************************************************************
  localparam int unsigned RESET_HOLD_CYCLES = 4096;
  localparam int unsigned FAULT_HOLD_CYCLES = 4096;
  localparam int unsigned FAULT_MIN_CYCLES  = 2048;
  localparam int unsigned WDOG_HOLD_CYCLES  = 4096;

  // ************************************************************
  // values after reset
  // ************************************************************
  localparam logic [15:0] BOOT_ADDR        = 16'h0000;
  localparam logic [7:0]  CFG_DEFAULT      = 8'h00;
  localparam logic [1:0]  SYNTH_STAT_CLEAR = 2'h0;

  // ************************************************************
  // sequencer states
  // ************************************************************
  typedef enum logic [2:0] {
    RPFS_RUN       = 3'b000,
    RPFS_EXT_RESET = 3'b001,
    RPFS_POWERDOWN = 3'b010,
    RPFS_HOLD      = 3'b011,
    RPFS_WDOG      = 3'b100
  } rpfs_state_t;

  // ************************************************************
  // control bundle toward the core
  // ************************************************************
  typedef struct packed {
    logic        core_reset;
    logic        digital_halt;
    logic        cfg_default_load;
    logic        synth_stat_clear;
    logic        ram_init;
    logic        power_down;
    logic [15:0] start_addr;
  } rpfs_ctrl_t;

endpackage

// ### core/rpfs_sync.sv
module rpfs_sync #(
  parameter logic RESET_VALUE = 1'b0
) (
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // ************************************************************
  // two-stage synchroniser
  // ************************************************************

  // first stage feeds only the second
  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // registers hold their reset value so no false event at start
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      meta_q <= RESET_VALUE;
      sync_q <= RESET_VALUE;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

// ### tb/rpfs_core_model.sv
// ************************************************************
// processor core seen from the sequencer
// ************************************************************
module rpfs_core_model (
  input  wire logic           sys_clk_in,
  input  rpfs_pkg::rpfs_ctrl_t ctrl_in,
  output logic                running_out,
  output logic [15:0]         fetch_addr_out,
  output logic                ram_wiped_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // held core loads its start address; runs only once released
  always_ff @(posedge sys_clk_in)
  begin
    if (ctrl_in.core_reset)
    begin
      running_out    <= 1'b0;
      fetch_addr_out <= ctrl_in.start_addr;
    end
    else
      running_out <= 1'b1;
  end

  // external reset forgets the wipe; only a fault recovery marks it
  always_ff @(posedge sys_clk_in)
  begin
    if (ctrl_in.cfg_default_load)
      ram_wiped_out <= 1'b0;
    else if (ctrl_in.core_reset && ctrl_in.ram_init)
      ram_wiped_out <= 1'b1;
  end
endmodule

// ### tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // short holds keep the run brief
  // ************************************************************
  localparam int unsigned HOLD = 8;

  logic                 sys_clk_in;
  logic                 rst_in;
  logic                 ext_reset_in;
  logic                 sense_in;
  logic                 wdog_in;
  rpfs_pkg::rpfs_ctrl_t ctrl;
  logic                 rtc_run;
  logic                 running;
  logic [15:0]          fetch_addr;
  logic                 ram_wiped;
  int                   failures;
  int                   total_checks;
  int                   n;

  rpfs_sequencer #(.RESET_HOLD(HOLD), .FAULT_HOLD(HOLD), .WDOG_HOLD(HOLD)) dut (
    .sys_clk_in                    (sys_clk_in),
    .rst_in                        (rst_in),
    .ext_reset_in                  (ext_reset_in),
    .power_fault_sense_input_in    (sense_in),
    .hardware_watchdog_overflow_in (wdog_in),
    .ctrl_out                      (ctrl),
    .rtc_run_out                   (rtc_run)
  );

  rpfs_core_model core (
    .sys_clk_in     (sys_clk_in),
    .ctrl_in        (ctrl),
    .running_out    (running),
    .fetch_addr_out (fetch_addr),
    .ram_wiped_out  (ram_wiped)
  );

  // 250 MHz clock
  initial
  begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  // ************************************************************
  // shared helpers
  // ************************************************************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // sample just after the edge so registered outputs have landed
  task automatic settle(input int cycles);
    repeat (cycles) @(posedge sys_clk_in);
    #1;
  endtask

  // bounded wait for the core to be let go
  task automatic count_release(output int cnt);
    cnt = 0;
    while (ctrl.core_reset !== 1'b0)
    begin
      if (cnt >= 200)
      begin
        failures++;
        $display("wrong value at %0t: core never released", $time);
        break;
      end
      settle(1);
      cnt++;
    end
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic test_reset();
    #1;
    check(ctrl.core_reset, 1'b1, "core held");
    check(ctrl.cfg_default_load, 1'b1, "cfg defaults");
    check(rtc_run, 1'b1, "clock kept");
    @(posedge sys_clk_in);
    rst_in <= 1'b0;
    count_release(n);
    check(16'(n >= HOLD && n <= HOLD + 4), 16'h0001, "hold length");
    settle(1);
    check(running, 1'b1, "core running");
    check(fetch_addr, rpfs_pkg::BOOT_ADDR, "boot address");
    $display("test reset done");
  endtask

  task automatic test_ext_reset();
    @(posedge sys_clk_in);
    ext_reset_in <= 1'b1;
    settle(4);
    check(ctrl.digital_halt, 1'b1, "halt");
    check(ctrl.cfg_default_load, 1'b1, "cfg defaults");
    check(rtc_run, 1'b1, "clock kept");
    settle(3 * HOLD);
    check(ctrl.core_reset, 1'b1, "held while pin high");
    @(posedge sys_clk_in);
    ext_reset_in <= 1'b0;
    count_release(n);
    check(16'(n >= HOLD && n <= HOLD + 4), 16'h0001, "hold length");
    settle(1);
    check(fetch_addr, 16'h0000, "boot address");
    check(ram_wiped, 1'b0, "no wipe without fault");
    $display("test external reset done");
  endtask

  task automatic test_fault();
    @(posedge sys_clk_in);
    sense_in <= 1'b0;
    settle(1);
    check(ctrl.power_down, 1'b0, "synchroniser delay");
    settle(4);
    check(ctrl.power_down, 1'b1, "power down");
    check(ctrl.synth_stat_clear, 1'b1, "status cleared");
    // a reset pulse while power is bad must not pull it out of power-down
    @(posedge sys_clk_in);
    ext_reset_in <= 1'b1;
    settle(6);
    check(ctrl.power_down, 1'b1, "reset refused");
    @(posedge sys_clk_in);
    ext_reset_in <= 1'b0;
    sense_in     <= 1'b1;
    settle(4);
    check(ctrl.ram_init, 1'b1, "ram init");
    count_release(n);
    check(16'(n + 4 >= HOLD && n + 4 <= HOLD + 4), 16'h0001, "fault hold");
    settle(1);
    check(fetch_addr, 16'h0000, "restart address");
    check(ram_wiped, 1'b1, "ram wiped");
    $display("test power fault done");
  endtask

  task automatic test_wdog();
    @(posedge sys_clk_in);
    wdog_in <= 1'b1;
    @(posedge sys_clk_in);
    wdog_in <= 1'b0;
    #1;
    check(ctrl.digital_halt, 1'b1, "wdog halt");
    settle(1);
    check(ctrl.core_reset, 1'b1, "wdog reset");
    check(ctrl.cfg_default_load, 1'b0, "cfg kept");
    count_release(n);
    check(16'(n + 1 >= HOLD && n + 1 <= HOLD + 4), 16'h0001, "wdog hold");
    settle(1);
    check(fetch_addr, 16'h0000, "restart address");
    $display("test watchdog done");
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    failures     = 0;
    total_checks = 0;
    rst_in       = 1'b1;
    ext_reset_in = 1'b0;
    sense_in     = 1'b1;
    wdog_in      = 1'b0;
    // reset stands for two edges: this one and the one test_reset releases on
    @(posedge sys_clk_in);
    test_reset();
    test_ext_reset();
    test_fault();
    test_wdog();
    stop_test();
  end
endmodule
